/* File: verilog/psmg_regs.sv */
// power-save and microphone gain register bank behind an APB slave
//
// Operation
// - bit 7 enables slide-switch power control
// - bit 3 enables headphone amplifier power save
// - bit 2 enables microphone amplifier power save
// - bit 0 enables filter opamp power save
// - right active gain: mute, 0dB up
// - left active gain: mute, 0dB up
// - right monitor gain: mute, 0.5dB up
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "psmg_params.svh"

module psmg_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // power-save controls
  output logic slide_switch_power_enable_out,
  output logic headphone_power_save_enable_out,
  output logic mic_power_save_enable_out,
  output logic filter_opamp_power_save_enable_out,
  // raw gain codes
  output psmg_pkg::psmg_gain_code_t right_mic_gain_code_out,
  output psmg_pkg::psmg_gain_code_t left_mic_gain_code_out,
  output psmg_pkg::psmg_gain_code_t right_monitor_gain_code_out,
  // decoded gains, half-dB units, one cycle behind the codes
  output logic right_mic_mute_out,
  output psmg_pkg::psmg_half_db_t right_mic_half_db_out,
  output logic left_mic_mute_out,
  output psmg_pkg::psmg_half_db_t left_mic_half_db_out,
  output logic right_monitor_mute_out,
  output psmg_pkg::psmg_half_db_t right_monitor_half_db_out
);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    addr_hit = (addr == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic psmg_pkg::psmg_reg_sel_e decode_addr(input logic [ADDR_W-1:0] addr);
    if (addr_hit(addr, `PSMG_IDX_PWR_SAVE)) begin
      decode_addr = psmg_pkg::PSMG_SEL_PWR_SAVE;
    end else if (addr_hit(addr, `PSMG_IDX_RGAIN)) begin
      decode_addr = psmg_pkg::PSMG_SEL_RGAIN;
    end else if (addr_hit(addr, `PSMG_IDX_LGAIN)) begin
      decode_addr = psmg_pkg::PSMG_SEL_LGAIN;
    end else if (addr_hit(addr, `PSMG_IDX_RMON)) begin
      decode_addr = psmg_pkg::PSMG_SEL_RMON;
    end else begin
      decode_addr = psmg_pkg::PSMG_SEL_NONE;
    end
  endfunction

  // only implemented bits take the written value
  function automatic psmg_pkg::psmg_byte_t merge_write(
    input psmg_pkg::psmg_byte_t old_val,
    input psmg_pkg::psmg_byte_t wdata,
    input psmg_pkg::psmg_byte_t mask
  );
    merge_write = (old_val & ~mask) | (wdata & mask);
  endfunction

  psmg_pkg::psmg_byte_t pwr_save_reg;
  psmg_pkg::psmg_byte_t pwr_save_next;
  psmg_pkg::psmg_byte_t rgain_reg;
  psmg_pkg::psmg_byte_t rgain_next;
  psmg_pkg::psmg_byte_t lgain_reg;
  psmg_pkg::psmg_byte_t lgain_next;
  psmg_pkg::psmg_byte_t rmon_reg;
  psmg_pkg::psmg_byte_t rmon_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  psmg_pkg::psmg_reg_sel_e sel;
  psmg_pkg::psmg_byte_t read_val;
  logic setup_phase;
  logic xfer_done;
  logic wr_en;

  assign sel = decode_addr(paddr_in);
  assign setup_phase = psel_in && !penable_in;
  // writes land only at the completing edge of the access phase
  assign xfer_done = psel_in && penable_in && pready_reg;
  assign wr_en = xfer_done && pwrite_in && pstrb_in[0];

  always_comb begin
    unique case (sel)
      psmg_pkg::PSMG_SEL_PWR_SAVE: read_val = pwr_save_reg & `PSMG_MASK_PWR_SAVE;
      psmg_pkg::PSMG_SEL_RGAIN: read_val = rgain_reg & `PSMG_MASK_GAIN;
      psmg_pkg::PSMG_SEL_LGAIN: read_val = lgain_reg & `PSMG_MASK_GAIN;
      psmg_pkg::PSMG_SEL_RMON: read_val = rmon_reg & `PSMG_MASK_MON;
      default: read_val = 8'h00;
    endcase
  end

  // register file
  always_comb begin
    pwr_save_next = pwr_save_reg;
    rgain_next = rgain_reg;
    lgain_next = lgain_reg;
    rmon_next = rmon_reg;
    if (wr_en) begin
      unique case (sel)
        psmg_pkg::PSMG_SEL_PWR_SAVE: begin
          pwr_save_next = merge_write(pwr_save_reg, pwdata_in[7:0], `PSMG_MASK_PWR_SAVE);
        end
        psmg_pkg::PSMG_SEL_RGAIN: begin
          // test bit stays writable; software is expected to keep it at one
          rgain_next = merge_write(rgain_reg, pwdata_in[7:0], `PSMG_MASK_GAIN);
        end
        psmg_pkg::PSMG_SEL_LGAIN: begin
          lgain_next = merge_write(lgain_reg, pwdata_in[7:0], `PSMG_MASK_GAIN);
        end
        psmg_pkg::PSMG_SEL_RMON: begin
          rmon_next = merge_write(rmon_reg, pwdata_in[7:0], `PSMG_MASK_MON);
        end
        default: begin
          pwr_save_next = pwr_save_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pwr_save_reg <= `PSMG_RST_PWR_SAVE;
      rgain_reg <= `PSMG_RST_RGAIN;
      lgain_reg <= `PSMG_RST_LGAIN;
      rmon_reg <= `PSMG_RST_RMON;
    end else begin
      pwr_save_reg <= pwr_save_next;
      rgain_reg <= rgain_next;
      lgain_reg <= lgain_next;
      rmon_reg <= rmon_next;
    end
  end

  // apb answer: read data and error captured in setup, one access cycle
  always_comb begin
    pready_next = pready_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      pready_next = 1'b1;
      prdata_next = pwrite_in ? 32'h0000_0000 : {24'h00_0000, read_val};
      pslverr_next = (sel == psmg_pkg::PSMG_SEL_NONE);
    end else if (xfer_done) begin
      pready_next = 1'b0;
      pslverr_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready_out = pready_reg;
  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg;

  // control bits leave straight from the register flops
  assign slide_switch_power_enable_out = pwr_save_reg[`PSMG_BIT_SLIDE];
  assign headphone_power_save_enable_out = pwr_save_reg[`PSMG_BIT_HPH_SAVE];
  assign mic_power_save_enable_out = pwr_save_reg[`PSMG_BIT_MIC_SAVE];
  assign filter_opamp_power_save_enable_out = pwr_save_reg[`PSMG_BIT_OPAMP_SAVE];

  assign right_mic_gain_code_out = rgain_reg[`PSMG_GAIN_MSB:`PSMG_GAIN_LSB];
  assign left_mic_gain_code_out = lgain_reg[`PSMG_GAIN_MSB:`PSMG_GAIN_LSB];
  assign right_monitor_gain_code_out = rmon_reg[`PSMG_GAIN_MSB:`PSMG_GAIN_LSB];

  // right active curve tops out 30 dB then jumps to 31 dB
  psmg_gain_decode #(
    .CODE_OFFSET(`PSMG_ACTIVE_CODE_OFFSET),
    .NEAR_TOP_HDB(`PSMG_RGAIN_NEAR_TOP_HDB),
    .TOP_HDB(`PSMG_TOP_HDB)
  ) u_rgain_dec (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .code_in(rgain_reg[`PSMG_GAIN_MSB:`PSMG_GAIN_LSB]),
    .mute_out(right_mic_mute_out),
    .half_db_out(right_mic_half_db_out)
  );

  psmg_gain_decode #(
    .CODE_OFFSET(`PSMG_ACTIVE_CODE_OFFSET),
    .NEAR_TOP_HDB(`PSMG_LGAIN_NEAR_TOP_HDB),
    .TOP_HDB(`PSMG_TOP_HDB)
  ) u_lgain_dec (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .code_in(lgain_reg[`PSMG_GAIN_MSB:`PSMG_GAIN_LSB]),
    .mute_out(left_mic_mute_out),
    .half_db_out(left_mic_half_db_out)
  );

  psmg_gain_decode #(
    .CODE_OFFSET(`PSMG_MON_CODE_OFFSET),
    .NEAR_TOP_HDB(`PSMG_MON_NEAR_TOP_HDB),
    .TOP_HDB(`PSMG_TOP_HDB)
  ) u_rmon_dec (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .code_in(rmon_reg[`PSMG_GAIN_MSB:`PSMG_GAIN_LSB]),
    .mute_out(right_monitor_mute_out),
    .half_db_out(right_monitor_half_db_out)
  );

endmodule

/* File: verilog/psmg_params.svh */
// register map, field layout, reset values and gain coding constants
`ifndef PSMG_PARAMS_SVH
`define PSMG_PARAMS_SVH

// register indices; byte address is four times the index
`define PSMG_IDX_PWR_SAVE 8'h17
`define PSMG_IDX_RGAIN 8'h30
`define PSMG_IDX_LGAIN 8'h31
`define PSMG_IDX_RMON 8'h32

// reset values
`define PSMG_RST_PWR_SAVE 8'h00
`define PSMG_RST_RGAIN 8'h80
`define PSMG_RST_LGAIN 8'h80
`define PSMG_RST_RMON 8'h00

// implemented bits; everything else reads zero and ignores writes
`define PSMG_MASK_PWR_SAVE 8'h8D
`define PSMG_MASK_GAIN 8'hBF
`define PSMG_MASK_MON 8'h3F

// power-save control field positions
`define PSMG_BIT_SLIDE 7
`define PSMG_BIT_HPH_SAVE 3
`define PSMG_BIT_MIC_SAVE 2
`define PSMG_BIT_OPAMP_SAVE 0

// gain field
`define PSMG_GAIN_LSB 0
`define PSMG_GAIN_MSB 5
`define PSMG_TEST_BIT 7
`define PSMG_GAIN_MUTE 6'h00
`define PSMG_GAIN_NEAR_TOP 6'h3E
`define PSMG_GAIN_TOP 6'h3F

// gain in half-dB units at the two top codes, per register
`define PSMG_RGAIN_NEAR_TOP_HDB 7'h3C
`define PSMG_LGAIN_NEAR_TOP_HDB 7'h3D
`define PSMG_MON_NEAR_TOP_HDB 7'h3D
`define PSMG_TOP_HDB 7'h3E

// offset subtracted from the code; code 1 maps to the first gain step: 0 dB (active) or 0.5 dB (monitor)
`define PSMG_ACTIVE_CODE_OFFSET 1
`define PSMG_MON_CODE_OFFSET 0

`endif

/* File: verilog/psmg_pkg.sv */
// types shared by the power-save and microphone gain register bank
package psmg_pkg;

  typedef enum logic [2:0] {
    PSMG_SEL_NONE = 3'b000,
    PSMG_SEL_PWR_SAVE = 3'b001,
    PSMG_SEL_RGAIN = 3'b010,
    PSMG_SEL_LGAIN = 3'b011,
    PSMG_SEL_RMON = 3'b100
  } psmg_reg_sel_e;

  typedef logic [7:0] psmg_byte_t;
  typedef logic [5:0] psmg_gain_code_t;
  typedef logic [6:0] psmg_half_db_t;

endpackage

/* File: verilog/psmg_gain_decode.sv */
// gain code to mute flag and gain in half-dB steps, registered
`timescale 1ns/1ns
`include "psmg_params.svh"

module psmg_gain_decode #(
  parameter int CODE_OFFSET = `PSMG_ACTIVE_CODE_OFFSET,
  parameter psmg_pkg::psmg_half_db_t NEAR_TOP_HDB = `PSMG_LGAIN_NEAR_TOP_HDB,
  parameter psmg_pkg::psmg_half_db_t TOP_HDB = `PSMG_TOP_HDB
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // code from the register
  input wire psmg_pkg::psmg_gain_code_t code_in,
  // decoded gain
  output logic mute_out,
  output psmg_pkg::psmg_half_db_t half_db_out
);

  logic mute_reg;
  logic mute_next;
  psmg_pkg::psmg_half_db_t half_db_reg;
  psmg_pkg::psmg_half_db_t half_db_next;

  // top two codes are listed per register; the right active curve is not linear there
  always_comb begin
    mute_next = (code_in == `PSMG_GAIN_MUTE);
    if (code_in == `PSMG_GAIN_MUTE) begin
      half_db_next = 7'h00;
    end else if (code_in == `PSMG_GAIN_NEAR_TOP) begin
      half_db_next = NEAR_TOP_HDB;
    end else if (code_in == `PSMG_GAIN_TOP) begin
      half_db_next = TOP_HDB;
    end else begin
      half_db_next = 7'({1'b0, code_in} - 7'(CODE_OFFSET));
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mute_reg <= 1'b1;
      half_db_reg <= 7'h00;
    end else begin
      mute_reg <= mute_next;
      half_db_reg <= half_db_next;
    end
  end

  assign mute_out = mute_reg;
  assign half_db_out = half_db_reg;

endmodule

/* File: test/psmg_regs_assertions.sv */
// assertion checker for the power-save and gain register bank
`timescale 1ns/1ns
module psmg_regs_chk #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // controls
  input wire logic slide_switch_power_enable_out,
  input wire psmg_pkg::psmg_gain_code_t right_mic_gain_code_out,
  input wire psmg_pkg::psmg_gain_code_t right_monitor_gain_code_out,
  input wire logic right_mic_mute_out,
  input wire psmg_pkg::psmg_half_db_t right_monitor_half_db_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic wr;
  logic mapped;
  assign wr = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
  assign mapped = paddr_in inside {8'h5C, 8'hC0, 8'hC4, 8'hC8};
  chk_ready_pulse: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("pready not a one-cycle answer to setup");
  chk_ready_cause: assert property (pready_out |-> $past(psel_in && !penable_in))
    else $error("pready without setup");
  chk_err_unmapped: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("pslverr wrong for address");
  chk_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_slide_write: assert property (
    wr && paddr_in == 8'h5C |=> slide_switch_power_enable_out == $past(pwdata_in[7]))
    else $error("slide enable not written");
  chk_rgain_write: assert property (
    wr && paddr_in == 8'hC0 |=> right_mic_gain_code_out == $past(pwdata_in[5:0]))
    else $error("right gain code not written");
  chk_mon_write: assert property (
    wr && paddr_in == 8'hC8 |=> right_monitor_gain_code_out == $past(pwdata_in[5:0]))
    else $error("monitor gain code not written");
  chk_rmute_follow: assert property (
    right_mic_mute_out == ($past(right_mic_gain_code_out) == 6'h00))
    else $error("right mute does not follow code");
  chk_mon_hdb: assert property (
    right_monitor_half_db_out ==
    (($past(right_monitor_gain_code_out) < 6'h3E) ? {1'b0, $past(right_monitor_gain_code_out)}
    : {1'b0, $past(right_monitor_gain_code_out)} - 7'h01))
    else $error("monitor gain decode wrong");
endmodule
bind psmg_regs psmg_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .slide_switch_power_enable_out(slide_switch_power_enable_out),
  .right_mic_gain_code_out(right_mic_gain_code_out),
  .right_monitor_gain_code_out(right_monitor_gain_code_out),
  .right_mic_mute_out(right_mic_mute_out),
  .right_monitor_half_db_out(right_monitor_half_db_out));

/* File: test/psmg_regs_bench.sv */
// self-checking bench for the power-save and gain register bank
`timescale 1ns/1ns
module psmg_regs_bench;
  logic clk, rst, psel, pen, pwr, sl, hs, ms, os, pready, perr, rmu, lmu, mmu;
  logic [7:0] paddr;
  logic [31:0] pwd, prd, d;
  logic [3:0] pst;
  psmg_pkg::psmg_gain_code_t rc, lc, mc;
  psmg_pkg::psmg_half_db_t rh, lh, mh;
  logic [7:0] mdl [4];
  localparam logic [7:0] ADR [4] = '{8'h5C, 8'hC0, 8'hC4, 8'hC8};
  localparam logic [7:0] MSK [4] = '{8'h8D, 8'hBF, 8'hBF, 8'h3F};
  localparam logic [7:0] RST [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
  localparam logic [5:0] BND [4] = '{6'h00, 6'h01, 6'h3E, 6'h3F};
  integer error_cnt = 0;
  integer checks_done = 0;
  integer seed;
  int j;
  psmg_regs dut (
    .clk_in(clk), .srst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwd), .pstrb_in(pst), .prdata_out(prd),
    .pready_out(pready), .pslverr_out(perr), .slide_switch_power_enable_out(sl),
    .headphone_power_save_enable_out(hs), .mic_power_save_enable_out(ms),
    .filter_opamp_power_save_enable_out(os), .right_mic_gain_code_out(rc),
    .left_mic_gain_code_out(lc), .right_monitor_gain_code_out(mc),
    .right_mic_mute_out(rmu), .right_mic_half_db_out(rh), .left_mic_mute_out(lmu),
    .left_mic_half_db_out(lh), .right_monitor_mute_out(mmu),
    .right_monitor_half_db_out(mh));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // k: 0 right active, 1 left active, 2 monitor
  function automatic logic [6:0] hdb(input logic [5:0] c, input int k);
    if (c == 6'h00) return 7'h00;
    if (k == 2 && c < 6'h3E) return {1'b0, c};
    if (k == 0 && c == 6'h3E) return 7'h3C;
    return {1'b0, c} - 7'h01;
  endfunction
  function automatic int idx(input logic [7:0] a);
    for (int i = 0; i < 4; i++) begin
      if (ADR[i] == a) return i;
    end
    return -1;
  endfunction
  // leaves the bus held so a following call makes a back-to-back transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] s);
    int i;
    int n;
    i = idx(a);
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= wd;
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    cmp("pslverr", 32'(i < 0), 32'(perr));
    if (!w) begin
      cmp("prdata", (i < 0) ? 32'h0 : {24'h0, mdl[i]}, prd);
    end else if (i >= 0 && s[0]) begin
      mdl[i] = wd[7:0] & MSK[i];
    end
  endtask
  task automatic idle_chk();
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp("slide", 32'(mdl[0][7]), 32'(sl));
    cmp("hph", 32'(mdl[0][3]), 32'(hs));
    cmp("mic", 32'(mdl[0][2]), 32'(ms));
    cmp("opamp", 32'(mdl[0][0]), 32'(os));
    cmp("rcode", 32'(mdl[1][5:0]), 32'(rc));
    cmp("rmute", 32'(mdl[1][5:0] == 6'h00), 32'(rmu));
    cmp("rhdb", 32'(hdb(mdl[1][5:0], 0)), 32'(rh));
    cmp("lcode", 32'(mdl[2][5:0]), 32'(lc));
    cmp("lmute", 32'(mdl[2][5:0] == 6'h00), 32'(lmu));
    cmp("lhdb", 32'(hdb(mdl[2][5:0], 1)), 32'(lh));
    cmp("mcode", 32'(mdl[3][5:0]), 32'(mc));
    cmp("mmute", 32'(mdl[3][5:0] == 6'h00), 32'(mmu));
    cmp("mhdb", 32'(hdb(mdl[3][5:0], 2)), 32'(mh));
    @(posedge clk);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
    xfer(1'b1, a, wd, s);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, ADR[i], 32'h0, 4'hF);
    end
    idle_chk();
  endtask
  initial begin
    seed = 32'h7F22;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwd = 32'h0;
    pst = 4'hF;
    for (int i = 0; i < 4; i++) begin
      mdl[i] = RST[i];
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, 8'h00, 32'h0, 4'hF);
    wr_chk(8'h60, 32'hFF, 4'hF);
    for (int b = 0; b < 8; b++) begin
      wr_chk(ADR[0], {24'hFFFFFF, 8'h01 << b}, 4'hF);
    end
    wr_chk(ADR[0], 32'hFF, 4'hF);
    for (int k = 1; k < 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        // test bit kept set on the active gains
        wr_chk(ADR[k], {24'h0, k < 3, 1'b0, BND[c]}, 4'hF);
      end
    end
    wr_chk(ADR[1], 32'h81, 4'hE);
    for (int n = 0; n < 40; n++) begin
      d = $random(seed);
      j = {$random(seed)} % 4;
      if (j == 1 || j == 2) begin
        d[7] = 1'b1;
      end
      wr_chk(ADR[j], d, {3'h7, d[9:8] != 2'b00});
    end
    // mid-run reset with the bus idle must bring back every reset value
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      mdl[i] = RST[i];
    end
    @(posedge clk);
    wr_chk(8'h60, 32'hFF, 4'hF);
    end_of_test();
  end
endmodule
